// >>> design/vttc_top.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "vttc_defs.svh"
// Function
// - software vector address is base plus software vector bits 6:0 shifted one
// - fetch record start from the vector slot, then the record itself
// - each slot is two bytes and gives the low bits of a RAM address
// - converter end uses slot 0438, enable B bit 6
// - timer channel 0 uses slots 0440 to 0446, enable B bits 5 to 2
// - timer 1 at 0450/0452 B1,B0; timer 2 at 0458/045A C7,C6
// - timer 3 0460-0466, timer 4 0470/0472 in C, timer 5 0478/047A in D
// - dma ends use slots 0490 to 0496, enable E bits 7 to 4
// - serial slots 04A2,04A4,04AA,04AC with E bits 3 to 0, lowest last
// - record order: mode A, source, mode B, destination, count A, count B
// - chained records follow one another in memory
// - normal mode counts with the full count A, count B ignored
// - repeat mode: count A high is reload, count A low counts down
// - repeat expiry reloads counter and repeat-area address, no interrupt
// - block end restores block counter and block-area address
// - block mode: A high size, A low in-block count, B block count
// - block mode ends after up to 65536 blocks with a CPU interrupt
// - chained transfers neither interrupt nor clear the source flag
// - updated record is written back after each transfer, in block mode only after each block
// - at the end clear source flag or enable bit per select bit and expiry
module vttc_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // activation request levels, index order is priority order
  input wire logic [32:0] SRC_REQ,
  // per-source flag clear pulse and CPU interrupt request pulse
  output logic [32:0] SRC_CLR,
  output logic [32:0] CPU_IRQ,
  // internal memory bus, 16-bit word, answer with ack
  output vttc_pkg::vttc_mem_req_type MEM_REQ,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  // busy indication
  output logic BUSY
);
  ////////////////////////////////////////////////////////////////////////////
  // source table: index 0..7 pins, then converter, timers, dma, serial
  function automatic logic [15:0] slot_of(input logic [5:0] i);
    logic [15:0] s;
    s = 16'h0000;
    case (i)
      6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07: begin
        s = 16'h0420 + {9'h000, i[2:0], 1'b0};
      end
      6'h08: s = 16'h0438;
      6'h09: s = 16'h0440;
      6'h0A: s = 16'h0442;
      6'h0B: s = 16'h0444;
      6'h0C: s = 16'h0446;
      6'h0D: s = 16'h0450;
      6'h0E: s = 16'h0452;
      6'h0F: s = 16'h0458;
      6'h10: s = 16'h045A;
      6'h11: s = 16'h0460;
      6'h12: s = 16'h0462;
      6'h13: s = 16'h0464;
      6'h14: s = 16'h0466;
      6'h15: s = 16'h0470;
      6'h16: s = 16'h0472;
      6'h17: s = 16'h0478;
      6'h18: s = 16'h047A;
      6'h19: s = 16'h0490;
      6'h1A: s = 16'h0492;
      6'h1B: s = 16'h0494;
      6'h1C: s = 16'h0496;
      6'h1D: s = 16'h04A2;
      6'h1E: s = 16'h04A4;
      6'h1F: s = 16'h04AA;
      6'h20: s = 16'h04AC;
      default: s = 16'h0000;
    endcase
    return s;
  endfunction

  // address step for one transfer by mode bits and size
  function automatic logic [23:0] step(input logic [23:0] a, input logic [1:0] m,
                                       input logic sz);
    logic [23:0] d;
    d = sz ? 24'h000002 : 24'h000001;
    case (m)
      2'h2: step = a + d;
      2'h3: step = a - d;
      default: step = a;
    endcase
  endfunction

  // start of a repeat or block area, from the address of its last element
  function automatic logic [23:0] restore(input logic [23:0] a, input logic [1:0] m,
                                          input logic sz, input logic [7:0] n);
    logic [23:0] back;
    back = 24'(n - 8'h01) << sz; // a size of zero means 256 elements
    case (m)
      2'h2: restore = a - back;
      2'h3: restore = a + back;
      default: restore = a;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // enable registers A..E and software vector register
  logic [7:0] en_r [0:4];
  logic [7:0] swv_r;
  // software run ended with an interrupt; blocks a rerun until software rewrites
  logic sw_done_r;
  logic [32:0] en_vec;
  logic clr_en;
  logic clr_sw;
  logic [5:0] cur_r;
  logic cur_sw_r;
  // enable bit of each source, in the same order as the slot table
  assign en_vec = {en_r[4][0], en_r[4][1], en_r[4][2], en_r[4][3],
                   en_r[4][4], en_r[4][5], en_r[4][6], en_r[4][7],
                   en_r[3][4], en_r[3][5], en_r[2][0], en_r[2][1],
                   en_r[2][2], en_r[2][3], en_r[2][4], en_r[2][5],
                   en_r[2][6], en_r[2][7], en_r[1][0], en_r[1][1],
                   en_r[1][2], en_r[1][3], en_r[1][4], en_r[1][5],
                   en_r[1][6], en_r[0][0], en_r[0][1], en_r[0][2],
                   en_r[0][3], en_r[0][4], en_r[0][5], en_r[0][6], en_r[0][7]};

  // enable table position of a source index, register and bit
  function automatic logic [5:0] en_pos(input logic [5:0] i);
    logic [5:0] p;
    p = 6'h00;
    case (i)
      6'h08: p = {3'h1, 3'h6};
      6'h15: p = {3'h2, 3'h1};
      6'h16: p = {3'h2, 3'h0};
      6'h17: p = {3'h3, 3'h5};
      6'h18: p = {3'h3, 3'h4};
      default: begin
        if (i < 6'h08) p = {3'h0, 3'h7 - i[2:0]};
        else if (i < 6'h0F) p = {3'h1, 3'(6'h0E - i)};
        else if (i < 6'h15) p = {3'h2, 3'(6'h16 - i)};
        else p = {3'h4, 3'(6'h20 - i)};
      end
    endcase
    return p;
  endfunction

  // register writes; hardware clear of an enable bit loses to a software set
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int k = 0; k < 5; k++) en_r[k] <= 8'h00;
    end else begin
      if (clr_en) begin
        en_r[en_pos(cur_r)[5:3]][en_pos(cur_r)[2:0]] <= 1'b0;
      end
      if (REG_WR && REG_ADDR <= `VTTC_OFS_ENE) begin
        en_r[REG_ADDR[2:0]] <= REG_WDATA;
      end
    end
  end

  // software vector register; the done-clear loses to a new write
  always_ff @(posedge CLK) begin
    if (RST) begin
      swv_r <= `VTTC_SWV_RST;
    end else if (REG_WR && REG_ADDR == `VTTC_OFS_SWV) begin
      swv_r <= REG_WDATA;
    end else if (clr_sw) begin
      swv_r[`VTTC_SWV_ACT_BIT] <= 1'b0;
    end
  end

  // read data one cycle after the strobe, unmapped reads return zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `VTTC_OFS_ENA, `VTTC_OFS_ENB, `VTTC_OFS_ENC, `VTTC_OFS_END,
        `VTTC_OFS_ENE: REG_RDATA <= en_r[REG_ADDR[2:0]];
        `VTTC_OFS_SWV: REG_RDATA <= swv_r;
        `VTTC_OFS_STAT: REG_RDATA <= {cur_sw_r, sw_done_r, cur_r};
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // controller state machine
  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_VEC = 8'h02, S_RREC = 8'h04, S_DRD = 8'h08,
    S_DWR = 8'h10, S_WB = 8'h20, S_END = 8'h40, S_NEXT = 8'h80
  } vttc_state_type;
  vttc_state_type st_r;
  logic [32:0] pend;
  logic [5:0] win;
  logic any_pend;
  logic [23:0] rec_base_r;
  logic [2:0] widx_r;
  logic [15:0] data_r;
  vttc_pkg::vttc_rec_type rec_r;
  logic [23:0] mem_q;
  logic blk_last;
  logic expired_r;

  assign pend = SRC_REQ & en_vec;
  assign any_pend = (|pend) || (swv_r[`VTTC_SWV_ACT_BIT] && !sw_done_r);
  // fixed priority: lowest index wins, software above all
  always_comb begin
    win = 6'h00;
    for (int k = 32; k >= 0; k--) begin
      if (pend[k]) win = 6'(k);
    end
  end

  // record mirror memory, also read back for inspection
  vttc_rec_mem u_rec (
    .CLK(CLK),
    .we(st_r == S_RREC && MEM_ACK),
    .waddr(widx_r),
    .wdata({8'h00, MEM_RDATA}),
    .raddr(widx_r),
    .rdata(mem_q)
  );

  vttc_pkg::vttc_mode_type mode;
  logic chain;
  logic interrupt_select_bit;
  assign mode = vttc_pkg::vttc_mode_type'(rec_r.mode_word_a[`VTTC_MRA_MD_HI:`VTTC_MRA_MD_LO]);
  assign chain = rec_r.mode_word_b[`VTTC_MRB_CHAIN];
  assign interrupt_select_bit = rec_r.mode_word_b[`VTTC_MRB_INTERRUPT_SELECT_BIT];
  assign blk_last = rec_r.count_a[7:0] == 8'h01;

  // main sequence
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= S_IDLE;
      cur_r <= 6'h00;
      cur_sw_r <= 1'b0;
      rec_base_r <= 24'h000000;
      widx_r <= 3'h0;
      data_r <= 16'h0000;
      rec_r <= '0;
      expired_r <= 1'b0;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (any_pend) begin
            cur_sw_r <= swv_r[`VTTC_SWV_ACT_BIT] && !sw_done_r;
            cur_r <= win;
            st_r <= S_VEC;
          end
        end
        S_VEC: begin
          if (MEM_ACK) begin
            // slot gives low bits of a RAM address, OR-ed onto the RAM base unaligned
            rec_base_r <= `VTTC_RAM_BASE | {8'h00, MEM_RDATA};
            widx_r <= 3'h0;
            st_r <= S_RREC;
          end
        end
        S_RREC: begin
          if (MEM_ACK) begin
            case (widx_r)
              `VTTC_REC_MRA: rec_r.mode_word_a <= MEM_RDATA;
              `VTTC_REC_SAR: rec_r.source_address_word <= `VTTC_RAM_BASE ^ 24'hFF0000 | {8'h00, MEM_RDATA};
              `VTTC_REC_MRB: rec_r.mode_word_b <= MEM_RDATA;
              `VTTC_REC_DAR: rec_r.destination_address_word <= `VTTC_RAM_BASE ^ 24'hFF0000 | {8'h00, MEM_RDATA};
              `VTTC_REC_CRA: rec_r.count_a <= MEM_RDATA;
              default: rec_r.count_b <= MEM_RDATA;
            endcase
            if (widx_r == `VTTC_REC_CRB) st_r <= S_DRD;
            widx_r <= widx_r + 3'h1;
          end
        end
        S_DRD: begin
          if (MEM_ACK) begin
            data_r <= MEM_RDATA;
            st_r <= S_DWR;
          end
        end
        S_DWR: begin
          if (MEM_ACK) begin
            rec_r.source_address_word <= step(rec_r.source_address_word, rec_r.mode_word_a[15:14], rec_r.mode_word_a[`VTTC_MRA_SZ]);
            rec_r.destination_address_word <= step(rec_r.destination_address_word, rec_r.mode_word_a[13:12], rec_r.mode_word_a[`VTTC_MRA_SZ]);
            case (mode)
              vttc_pkg::VTTC_REPEAT: begin
                expired_r <= 1'b0;
                if (rec_r.count_a[7:0] == 8'h01) begin
                  rec_r.count_a[7:0] <= rec_r.count_a[15:8];
                  // restore repeat-area address by undoing the whole run
                  if (rec_r.mode_word_a[`VTTC_MRA_DTS])
                    rec_r.source_address_word <= restore(rec_r.source_address_word, rec_r.mode_word_a[15:14],
                                         rec_r.mode_word_a[`VTTC_MRA_SZ], rec_r.count_a[15:8]);
                  else
                    rec_r.destination_address_word <= restore(rec_r.destination_address_word, rec_r.mode_word_a[13:12],
                                         rec_r.mode_word_a[`VTTC_MRA_SZ], rec_r.count_a[15:8]);
                end else rec_r.count_a[7:0] <= rec_r.count_a[7:0] - 8'h01;
              end
              vttc_pkg::VTTC_BLOCK: begin
                rec_r.count_a[7:0] <= rec_r.count_a[7:0] - 8'h01;
                if (!blk_last) begin
                  st_r <= S_DRD;
                end else begin
                  rec_r.count_a[7:0] <= rec_r.count_a[15:8];
                  if (rec_r.mode_word_a[`VTTC_MRA_DTS])
                    rec_r.source_address_word <= restore(rec_r.source_address_word, rec_r.mode_word_a[15:14],
                                         rec_r.mode_word_a[`VTTC_MRA_SZ], rec_r.count_a[15:8]);
                  else
                    rec_r.destination_address_word <= restore(rec_r.destination_address_word, rec_r.mode_word_a[13:12],
                                         rec_r.mode_word_a[`VTTC_MRA_SZ], rec_r.count_a[15:8]);
                  rec_r.count_b <= rec_r.count_b - 16'h0001;
                  expired_r <= rec_r.count_b == 16'h0001;
                end
              end
              default: begin
                rec_r.count_a <= rec_r.count_a - 16'h0001;
                expired_r <= rec_r.count_a == 16'h0001;
              end
            endcase
            if (mode != vttc_pkg::VTTC_BLOCK || blk_last) begin
              widx_r <= 3'h0;
              st_r <= S_WB;
            end
          end
        end
        S_WB: begin
          if (MEM_ACK) begin
            widx_r <= widx_r + 3'h1;
            if (widx_r == `VTTC_REC_CRB) st_r <= chain ? S_NEXT : S_END;
          end
        end
        S_NEXT: begin
          rec_base_r <= rec_base_r + 24'h00000C;
          widx_r <= 3'h0;
          st_r <= S_RREC;
        end
        S_END: st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory request: vector slot, record words, data, write-back
  logic [15:0] wb_word;
  always_comb begin
    case (widx_r)
      `VTTC_REC_MRA: wb_word = rec_r.mode_word_a;
      `VTTC_REC_SAR: wb_word = rec_r.source_address_word[15:0];
      `VTTC_REC_MRB: wb_word = rec_r.mode_word_b;
      `VTTC_REC_DAR: wb_word = rec_r.destination_address_word[15:0];
      `VTTC_REC_CRA: wb_word = rec_r.count_a;
      default: wb_word = rec_r.count_b;
    endcase
  end
  always_comb begin
    MEM_REQ = '0;
    case (st_r)
      S_VEC: begin
        MEM_REQ.req = 1'b1;
        MEM_REQ.addr = {8'h00, cur_sw_r ?
          (`VTTC_VEC_BASE + {8'h00, swv_r[6:0], 1'b0}) : slot_of(cur_r)};
      end
      S_RREC, S_WB: begin
        MEM_REQ.req = 1'b1;
        MEM_REQ.we = st_r == S_WB;
        MEM_REQ.addr = rec_base_r + {20'h00000, widx_r, 1'b0};
        MEM_REQ.wdata = wb_word;
      end
      S_DRD: begin
        MEM_REQ.req = 1'b1;
        MEM_REQ.addr = rec_r.source_address_word;
      end
      S_DWR: begin
        MEM_REQ.req = 1'b1;
        MEM_REQ.we = 1'b1;
        MEM_REQ.addr = rec_r.destination_address_word;
        MEM_REQ.wdata = data_r;
      end
      default: MEM_REQ = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // end of activation: chained records never reach here
  logic fin;
  logic to_cpu;
  assign fin = st_r == S_END;
  assign to_cpu = interrupt_select_bit || expired_r;
  assign clr_en = fin && !cur_sw_r && to_cpu;
  assign clr_sw = fin && cur_sw_r && !to_cpu;
  // software end interrupt shows in status; the activate bit stays set
  always_ff @(posedge CLK) begin
    if (RST) begin
      sw_done_r <= 1'b0;
    end else if (REG_WR && REG_ADDR == `VTTC_OFS_SWV) begin
      sw_done_r <= 1'b0;
    end else if (fin && cur_sw_r && to_cpu) begin
      sw_done_r <= 1'b1;
    end
  end
  always_comb begin
    SRC_CLR = '0;
    CPU_IRQ = '0;
    if (fin && !cur_sw_r) begin
      if (to_cpu) CPU_IRQ[cur_r] = 1'b1;
      else SRC_CLR[cur_r] = 1'b1;
    end
  end
  assign BUSY = st_r != S_IDLE;

  chk_idle_vec: assert property (@(posedge CLK) disable iff (RST)
    st_r == S_IDLE && any_pend |=> st_r == S_VEC) else $error("no vector fetch");
  chk_sw_addr: assert property (@(posedge CLK) disable iff (RST)
    st_r == S_VEC && cur_sw_r |-> MEM_REQ.addr[15:0] == 16'h0400 + {swv_r[6:0], 1'b0})
    else $error("bad software vector");
  chk_chain_quiet: assert property (@(posedge CLK) disable iff (RST)
    st_r == S_NEXT |-> SRC_CLR == '0 && CPU_IRQ == '0) else $error("chain side effect");
  chk_wb_write: assert property (@(posedge CLK) disable iff (RST)
    st_r == S_WB |-> MEM_REQ.we) else $error("write-back not a write");
  chk_end_one: assert property (@(posedge CLK) disable iff (RST)
    fin |-> !(clr_en && clr_sw)) else $error("double clear");
  chk_next_rec: assert property (@(posedge CLK) disable iff (RST)
    st_r == S_NEXT |=> st_r == S_RREC && rec_base_r == $past(rec_base_r) + 24'h00000C)
    else $error("next record not adjacent");
endmodule

// >>> design/vttc_defs.svh
`ifndef VTTC_DEFS_SVH
`define VTTC_DEFS_SVH
// register offsets on the plain register port
`define VTTC_OFS_ENA 4'h0
`define VTTC_OFS_ENB 4'h1
`define VTTC_OFS_ENC 4'h2
`define VTTC_OFS_END 4'h3
`define VTTC_OFS_ENE 4'h4
`define VTTC_OFS_SWV 4'h5
`define VTTC_OFS_STAT 4'h6
// software vector register fields
`define VTTC_SWV_ACT_BIT 7
`define VTTC_SWV_RST 8'h00
// vector table
`define VTTC_VEC_BASE 16'h0400
`define VTTC_RAM_BASE 24'hFFF800
`define VTTC_NSRC 33
// record word offsets in words, doubled for the byte address
`define VTTC_REC_MRA 3'h0
`define VTTC_REC_SAR 3'h1
`define VTTC_REC_MRB 3'h2
`define VTTC_REC_DAR 3'h3
`define VTTC_REC_CRA 3'h4
`define VTTC_REC_CRB 3'h5
`define VTTC_REC_WORDS 3'h6
// mode word fields
`define VTTC_MRA_MD_HI 11
`define VTTC_MRA_MD_LO 10
`define VTTC_MRA_DTS 9
`define VTTC_MRA_SZ 8
`define VTTC_MRA_SM_HI 15
`define VTTC_MRA_SM_LO 14
`define VTTC_MRA_DM_HI 13
`define VTTC_MRA_DM_LO 12
`define VTTC_MRB_CHAIN 15
`define VTTC_MRB_INTERRUPT_SELECT_BIT 14
`endif

// >>> design/vttc_pkg.sv
package vttc_pkg;
  typedef enum logic [1:0] {
    VTTC_NORMAL = 2'h0,
    VTTC_REPEAT = 2'h1,
    VTTC_BLOCK = 2'h2
  } vttc_mode_type;
  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } vttc_mem_req_type;
  typedef struct packed {
    logic [15:0] mode_word_a;
    logic [23:0] source_address_word;
    logic [15:0] mode_word_b;
    logic [23:0] destination_address_word;
    logic [15:0] count_a;
    logic [15:0] count_b;
  } vttc_rec_type;
endpackage

// >>> design/vttc_rec_mem.sv
`timescale 1ns/10ps
// working copy of one register-information record, six words
module vttc_rec_mem (
  // clock
  input wire logic CLK,
  // write side
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [23:0] wdata,
  // read side
  input wire logic [2:0] raddr,
  output logic [23:0] rdata
);
  logic [23:0] mem [0:5];
  // storage write
  always_ff @(posedge CLK) begin
    if (we && waddr < 3'h6) begin
      mem[waddr] <= wdata;
    end
  end
  // registered read keeps timing clean
  always_ff @(posedge CLK) begin
    rdata <= (raddr < 3'h6) ? mem[raddr] : 24'h000000;
  end
endmodule

// >>> bench/vttc_mem_model.sv
`timescale 1ns/10ps
// far side: source flags, interrupt capture and the word-wide on-chip memory
module vttc_mem_model (
  // clock
  input wire logic clk,
  // memory bus from the controller
  input wire vttc_pkg::vttc_mem_req_type mem_req,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // source flags with their clear and interrupt pulses
  input wire logic [32:0] raise,
  input wire logic [32:0] src_clr,
  input wire logic [32:0] cpu_irq,
  output logic [32:0] src_req,
  // bench control
  input wire logic [7:0] ack_delay,
  input wire logic clr_log
);
  logic [15:0] mem [logic [15:0]];
  logic [16:0] log_q [$];
  logic [32:0] clr_seen = '0;
  logic [32:0] irq_seen = '0;
  logic [7:0] wait_cnt = 8'h00;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    src_req = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // a flag stays up until cleared, so a missed clear shows as a second run
  always @(posedge clk) begin
    src_req <= (src_req | raise) & ~src_clr;
    if (clr_log) begin
      log_q.delete();
      clr_seen <= '0;
      irq_seen <= '0;
    end else begin
      clr_seen <= clr_seen | src_clr;
      irq_seen <= irq_seen | cpu_irq;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // ack after a chosen wait; data toggles when not acked so stale reads show
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req.req && mem_ack) begin
      log_q.push_back({mem_req.we, mem_req.addr[15:0]});
      if (mem_req.we) begin
        mem[mem_req.addr[15:0]] = mem_req.wdata;
      end
      wait_cnt <= 8'h00;
    end else if (mem_req.req) begin
      if (wait_cnt >= ack_delay) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem.exists(mem_req.addr[15:0]) ? mem[mem_req.addr[15:0]] : ~mem_rdata;
      end else begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end
endmodule

// >>> bench/vttc_top_tb.sv
`timescale 1ns/10ps
// bench: register tasks, activations and record checks
module vttc_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, rd_v;
  logic [32:0] src_req, src_clr, cpu_irq;
  logic [32:0] raise = '0;
  vttc_pkg::vttc_mem_req_type mem_req;
  logic mem_ack, busy;
  logic [15:0] mem_rdata;
  logic [7:0] ack_delay = 8'h01;
  logic clr_log = 1'b0;
  int failures = 0;
  int checks_done = 0;
  // slot per source, and enable as {register, bit}
  logic [15:0] slot [33] = '{16'h0420, 16'h0422, 16'h0424, 16'h0426, 16'h0428, 16'h042A,
    16'h042C, 16'h042E, 16'h0438, 16'h0440, 16'h0442, 16'h0444, 16'h0446, 16'h0450, 16'h0452,
    16'h0458, 16'h045A, 16'h0460, 16'h0462, 16'h0464, 16'h0466, 16'h0470, 16'h0472, 16'h0478,
    16'h047A, 16'h0490, 16'h0492, 16'h0494, 16'h0496, 16'h04A2, 16'h04A4, 16'h04AA, 16'h04AC};
  logic [7:0] enb [33] = '{8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00, 8'h16,
    8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h27, 8'h26, 8'h25, 8'h24, 8'h23, 8'h22, 8'h21,
    8'h20, 8'h35, 8'h34, 8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40};
  ////////////////////////////////////////////////////////////////////////////
  // clock at 40 MHz
  always #12.5 clk = ~clk;
  vttc_top i_vttc_top (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SRC_REQ(src_req),
    .SRC_CLR(src_clr), .CPU_IRQ(cpu_irq), .MEM_REQ(mem_req), .MEM_ACK(mem_ack),
    .MEM_RDATA(mem_rdata), .BUSY(busy));
  vttc_mem_model i_vttc_mem_model (.clk(clk), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .raise(raise), .src_clr(src_clr), .cpu_irq(cpu_irq),
    .src_req(src_req), .ack_delay(ack_delay), .clr_log(clr_log));
  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic reg_w(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_r(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  function automatic logic [16:0] lg(input int k);
    return i_vttc_mem_model.log_q[k];
  endfunction
  function automatic logic [15:0] mw(input logic [15:0] a);
    return i_vttc_mem_model.mem[a];
  endfunction
  // source and destination words are fixed for every record
  task automatic put_rec(input logic [15:0] b, m_a, m_b, c_a, c_b);
    i_vttc_mem_model.mem[b] = m_a;
    i_vttc_mem_model.mem[b + 16'h0002] = 16'hF900;
    i_vttc_mem_model.mem[b + 16'h0004] = m_b;
    i_vttc_mem_model.mem[b + 16'h0006] = 16'hFA00;
    i_vttc_mem_model.mem[b + 16'h0008] = c_a;
    i_vttc_mem_model.mem[b + 16'h000A] = c_b;
  endtask
  // waits until busy falls, bounded so a stuck engine counts as a mismatch
  task automatic settle;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 3000) failures++;
  endtask
  // an empty mask means a software activation through the vector register
  task automatic activate(input logic [32:0] m, input logic [7:0] swv);
    @(posedge clk);
    clr_log <= 1'b1;
    @(posedge clk);
    clr_log <= 1'b0;
    if (m == '0) begin
      reg_w(4'h5, swv);
    end else begin
      raise <= m;
      @(posedge clk);
      raise <= '0;
    end
    settle();
  endtask
  task automatic seen(input logic [32:0] clr_e, input logic [32:0] irq_e);
    check(i_vttc_mem_model.clr_seen, clr_e);
    check(i_vttc_mem_model.irq_seen, irq_e);
  endtask
  task automatic head(input logic [15:0] s, input int sz);
    check(lg(0), {1'b0, s});
    for (int k = 0; k < 6; k++) check(lg(k + 1), {1'b0, 16'hF800 + 16'(2 * k)});
    check(i_vttc_mem_model.log_q.size(), sz);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the expected run length
  initial begin
    #(25 * 40000);
    failures++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values and the unmapped offset
    reg_w(4'h7, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      reg_r(4'(a), rd_v);
      check(rd_v, 8'h00);
    end
    // every source in turn, normal mode, count not expired
    for (int i = 0; i < 33; i++) begin
      put_rec(16'hF800, 16'h2100, 16'h0000, 16'h0005, 16'h0000);
      i_vttc_mem_model.mem[slot[i]] = 16'hF800;
      i_vttc_mem_model.mem[16'hF900] = 16'h1200 + 16'(i);
      reg_w(4'(enb[i][6:4]), 8'h01 << enb[i][2:0]);
      activate(33'h1 << i, 8'h00);
      check(lg(0), {1'b0, slot[i]});
      head(slot[i], 15);
      check(lg(8), {1'b1, 16'hFA00});
      check(mw(16'hFA00), 16'h1200 + 16'(i));
      check(mw(16'hF808), 16'h0004);
      check(mw(16'hF806), 16'hFA02);
      seen(33'h1 << i, '0);
      reg_r(4'(enb[i][6:4]), rd_v);
      check(rd_v, 8'h01 << enb[i][2:0]);
      reg_w(4'(enb[i][6:4]), 8'h00);
    end
    // two pending at once: converter end wins over the last serial source
    reg_w(4'h1, 8'h40);
    reg_w(4'h4, 8'h01);
    activate(33'h1_0000_0100, 8'h00);
    check(lg(0), {1'b0, 16'h0438});
    settle();
    seen(33'h1_0000_0100, '0);
    // chain: first record expires yet raises nothing
    ack_delay <= 8'h03;
    put_rec(16'hF800, 16'h2100, 16'h8000, 16'h0001, 16'h0000);
    put_rec(16'hF80C, 16'h2100, 16'h0000, 16'h0005, 16'h0000);
    activate(33'h1 << 8, 8'h00);
    check(lg(15), {1'b0, 16'hF80C});
    check(i_vttc_mem_model.log_q.size(), 29);
    seen(33'h1 << 8, '0);
    // expiry on an interrupt source: interrupt, enable bit dropped
    put_rec(16'hF800, 16'h2100, 16'h0000, 16'h0001, 16'h0000);
    activate(33'h1 << 32, 8'h00);
    seen('0, 33'h1 << 32);
    check(mw(16'hF808), 16'h0000);
    reg_r(4'h4, rd_v);
    check(rd_v, 8'h00);
    // repeat: counter and source area come back, no interrupt
    ack_delay <= 8'h00;
    reg_w(4'h1, 8'h20);
    put_rec(16'hF800, 16'h8700, 16'h0000, 16'h0101, 16'h0000);
    activate(33'h1 << 9, 8'h00);
    check(mw(16'hF808), 16'h0101);
    check(mw(16'hF802), 16'hF900);
    seen(33'h1 << 9, '0);
    // block of two words, one block: area restored, other side advances
    put_rec(16'hF800, 16'hA900, 16'h0000, 16'h0202, 16'h0001);
    i_vttc_mem_model.mem[16'hF902] = 16'h3456;
    activate(33'h1 << 9, 8'h00);
    head(16'h0440, 17);
    check(lg(10), {1'b1, 16'hFA02});
    check(mw(16'hFA02), 16'h3456);
    check(mw(16'hF802), 16'hF904);
    check(mw(16'hF806), 16'hFA00);
    check(mw(16'hF808), 16'h0202);
    check(mw(16'hF80A), 16'h0000);
    seen('0, 33'h1 << 9);
    // software: plain run clears the activate bit, select bit keeps it
    put_rec(16'hF800, 16'h2100, 16'h0000, 16'h0005, 16'h0000);
    i_vttc_mem_model.mem[16'h0420] = 16'hF800;
    activate('0, 8'h90);
    check(lg(0), {1'b0, 16'h0420});
    reg_r(4'h5, rd_v);
    check(rd_v, 8'h10);
    put_rec(16'hF800, 16'h2100, 16'h4000, 16'h0005, 16'h0000);
    i_vttc_mem_model.mem[16'h04AA] = 16'hF800;
    activate('0, 8'hD5);
    check(lg(0), {1'b0, 16'h04AA});
    reg_r(4'h5, rd_v);
    check(rd_v, 8'hD5);
    reg_r(4'h6, rd_v);
    check(rd_v[6], 1'b1);
    wrap_up();
  end
endmodule
